// ### hdl/int_vec_pkg.sv
package int_vec_pkg;
   localparam logic [15:0] flags_low_addr   = 16'hfe04;
   localparam logic [15:0] flags_mid_addr   = 16'hfe05;
   localparam logic [7:0]  flags_reset      = 8'h00;
   localparam logic [15:0] stack_reset      = 16'h00ff;
   localparam logic [15:0] vec_timer_base   = 16'hffd2;
   localparam logic [15:0] vec_swi          = 16'hfffc;
   localparam logic [15:0] vec_reset        = 16'hfffe;
   localparam logic [4:0]  num_flags        = 5'h15;
   localparam logic [2:0]  irq_stack_bytes  = 3'h5;
   localparam logic [2:0]  call_stack_bytes = 3'h2;

   typedef enum logic [3:0] {
      st_idle  = 4'b0001,
      st_push  = 4'b0010,
      st_pull  = 4'b0100,
      st_done  = 4'b1000
   } stack_state_t;
endpackage

// ### hdl/interrupt_vector_and_stack.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// - flag 20, infrared port transmit, vectors at ffd4 and ffd5.
// - flag 19, infrared port receive, vectors at ffd6 and ffd7.
// - flag 18, infrared port error, vectors at ffd8 and ffd9.
// - flag 17, spi transmit, vectors at ffda and ffdb.
// - flag 16, spi receive, vectors at ffdc and ffdd.
// - flag 15, conversion done, vectors at ffde and ffdf.
// - flag 13, serial transmit, vectors at ffe2 and ffe3.
// - flag 12, serial receive, vectors at ffe4 and ffe5.
// - flag 11, serial error, vectors at ffe6 and ffe7.
// - flag 10, i2c module, vectors at ffe8 and ffe9.
// - flag 9, timer b overflow, vectors at ffea and ffeb.
// - timer b channel 1 at ffec, channel 0 at ffee.
// - timer a overflow fff0, channel 1 fff2, channel 0 fff4.
// - read-only fe04 shows flags 6..1 in bits 7..2, low bits zero.
// - read-only fe05 shows flags 14..7, resets to zero.
// - interrupt entry pushes five bytes, index high not saved.
// - subroutine call pushes a two-byte return address.
// - stack pointer decrements per push, increments per pull.
// - stack pointer is 16 bits, resets to 00ff.
module interrupt_vector_and_stack
   import int_vec_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [21:1] irq_flags,
   input  wire logic        swi_req,
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic             irq_pending,
   output logic      [4:0]  irq_source,
   output logic      [15:0] vec_addr_hi,
   output logic      [15:0] vec_addr_lo,
   input  wire logic        irq_entry,
   input  wire logic        call_entry,
   input  wire logic        return_req,
   input  wire logic        irq_return,
   output logic             stack_busy,
   output logic             stack_push,
   output logic             stack_pull,
   output logic      [15:0] stack_ptr,
   output logic      [2:0]  stack_byte
);

   logic [21:1]  flag_sync1_reg;
   logic [21:1]  flag_sync2_reg;
   logic [21:1]  flag_reg;
   logic [4:0]   win_next;
   logic         any_next;
   logic [15:0]  vec_next;
   logic [15:0]  sp_reg;
   logic [2:0]   cnt_reg;
   logic [2:0]   len_reg;
   stack_state_t state_reg;

   // vector high byte address of flag n; 1 is fffa, 21 is ffd2, two bytes each
   function automatic logic [15:0] vec_of(input logic [4:0] n);
      vec_of = 16'(vec_timer_base + 16'(2 * (21 - int'(n))));
   endfunction

   // flags come from peripherals that may sit on other clocks
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flag_sync1_reg <= '0;
         flag_sync2_reg <= '0;
         flag_reg       <= '0;
      end else begin
         flag_sync1_reg <= irq_flags;
         flag_sync2_reg <= flag_sync1_reg;
         flag_reg       <= flag_sync2_reg;
      end
   end

   // lowest flag number is highest priority
   always_comb begin
      win_next = '0;
      any_next = 1'b0;
      for (int i = 21; i >= 1; i--) begin
         if (flag_reg[i]) begin
            win_next = 5'(i);
            any_next = 1'b1;
         end
      end
      if (swi_req) begin
         vec_next = vec_swi;
      end else if (any_next) begin
         vec_next = vec_of(win_next);
      end else begin
         vec_next = vec_reset;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_pending <= 1'b0;
         irq_source  <= '0;
         vec_addr_hi <= vec_reset;
         vec_addr_lo <= vec_reset + 16'h0001;
      end else begin
         irq_pending <= any_next | swi_req;
         irq_source  <= win_next;
         vec_addr_hi <= vec_next;
         vec_addr_lo <= vec_next + 16'h0001;
      end
   end

   // writes to status registers are ignored; unmapped reads give zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= flags_reset;
      end else if (reg_rd) begin
         case (reg_addr)
            flags_low_addr: reg_rdata <= {flag_reg[6:1], 2'b00};
            flags_mid_addr: reg_rdata <= flag_reg[14:7];
            default:        reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // stack sequencer, one byte per cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= st_idle;
         cnt_reg   <= '0;
         len_reg   <= '0;
         sp_reg    <= stack_reset;
      end else begin
         case (state_reg)
            st_idle: begin
               if (irq_entry) begin
                  len_reg   <= irq_stack_bytes;
                  cnt_reg   <= '0;
                  state_reg <= st_push;
               end else if (call_entry) begin
                  len_reg   <= call_stack_bytes;
                  cnt_reg   <= '0;
                  state_reg <= st_push;
               end else if (irq_return) begin
                  len_reg   <= irq_stack_bytes;
                  cnt_reg   <= '0;
                  state_reg <= st_pull;
               end else if (return_req) begin
                  len_reg   <= call_stack_bytes;
                  cnt_reg   <= '0;
                  state_reg <= st_pull;
               end
            end
            st_push: begin
               sp_reg  <= sp_reg - 16'h0001;
               cnt_reg <= cnt_reg + 3'h1;
               if (cnt_reg + 3'h1 == len_reg) begin
                  state_reg <= st_done;
               end
            end
            st_pull: begin
               sp_reg  <= sp_reg + 16'h0001;
               cnt_reg <= cnt_reg + 3'h1;
               if (cnt_reg + 3'h1 == len_reg) begin
                  state_reg <= st_done;
               end
            end
            st_done: state_reg <= st_idle;
            default: state_reg <= st_idle;
         endcase
      end
   end

   assign stack_push = (state_reg == st_push);
   assign stack_pull = (state_reg == st_pull);
   assign stack_busy = (state_reg != st_idle);
   assign stack_ptr  = sp_reg;
   assign stack_byte = cnt_reg;

endmodule

// ### test/ivs_sva.sv
`timescale 1ns/1ps
module ivs_chk (
   input wire logic        sys_clk, rst, reg_rd, irq_entry, call_entry, stack_busy, stack_push, stack_pull, swi_req,
   input wire logic [4:0]  irq_source,
   input wire logic [7:0]  reg_rdata,
   input wire logic [15:0] reg_addr, stack_ptr, vec_addr_hi, vec_addr_lo
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_vec_pair: assert property (vec_addr_lo == vec_addr_hi + 16'h1)
      else $error("vector pair split");
   // software interrupt outranks every flag, so its cycles are left out
   chk_vec_map: assert property (irq_source != 0 && !$past(swi_req) |->
      vec_addr_hi == 16'(32'hffd2 + 2 * (21 - irq_source)))
      else $error("vector address wrong");
   chk_irq_push: assert property (irq_entry && !stack_busy |=> stack_push [*5] ##1 !stack_push)
      else $error("interrupt push count wrong");
   chk_call_push: assert property (call_entry && !irq_entry && !stack_busy |=> stack_push [*2] ##1 !stack_push)
      else $error("call push count wrong");
   chk_push_dec: assert property (stack_push |=> stack_ptr == $past(stack_ptr) - 16'h1)
      else $error("push did not decrement");
   chk_pull_inc: assert property (stack_pull |=> stack_ptr == $past(stack_ptr) + 16'h1)
      else $error("pull did not increment");
   chk_sp_reset: assert property (disable iff (1'b0) rst |-> stack_ptr == 16'h00ff)
      else $error("stack reset value wrong");
   chk_low_bits: assert property (reg_rd && reg_addr == 16'hfe04 |=> reg_rdata[1:0] == 2'b00)
      else $error("low status bits set");
   cover property (irq_entry && !stack_busy);
   cover property (call_entry && !stack_busy);
   cover property (reg_rd && reg_addr == 16'hfe05);
endmodule
bind interrupt_vector_and_stack ivs_chk chk (.*);

// ### test/ivs_cpu.sv
`timescale 1ns/1ps
module ivs_cpu (
   input wire logic       sys_clk, stack_busy,
   input wire logic [3:0] want,
   output logic           irq_entry, call_entry, irq_return, return_req
);
   // a request raised while busy would be lost, so hold it back
   always_ff @(posedge sys_clk) begin
      {irq_entry, call_entry, irq_return, return_req} <= stack_busy ? 4'h0 : want;
   end
endmodule

// ### test/interrupt_vector_and_stack_bench.sv
`timescale 1ns/1ps
module interrupt_vector_and_stack_bench;
   import int_vec_pkg::*;
   logic        sys_clk = 0, rst = 0, swi_req = 0, reg_wr = 0, reg_rd = 0;
   logic [21:1] irq_flags = '0;
   logic [15:0] reg_addr = '0, vec_addr_hi, vec_addr_lo, stack_ptr;
   logic [7:0]  reg_wdata = '0, reg_rdata;
   logic [3:0]  want = '0;
   logic        irq_pending, irq_entry, call_entry, irq_return, return_req, stack_busy, stack_push, stack_pull;
   logic [4:0]  irq_source;
   logic [2:0]  stack_byte;
   int          fails = 0, total_checks = 0, f, n, sp = 'h00ff;
   always #10 sys_clk = ~sys_clk;
   interrupt_vector_and_stack dut (.*);
   ivs_cpu cpu (.*);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge sys_clk);
      reg_rd <= 0;
      #1 chk(16'(reg_rdata), 16'(e));
   endtask
   task automatic setf(input logic [21:1] v, input logic s);
      logic [15:0] e;
      irq_flags <= v;
      swi_req <= s;
      repeat (5) @(posedge sys_clk);
      #1 f = int'(v) << 1;
      n = 0;
      for (int i = 21; i > 0; i--) if (f[i]) n = i;
      e = s ? vec_swi : n ? 16'(32'hffd2 + 2 * (21 - n)) : vec_reset;
      chk(vec_addr_hi, e);
      chk(vec_addr_lo, e + 16'h1);
      chk(16'(irq_pending), 16'(s || n != 0));
      if (!s) chk(16'(irq_source), 16'(n));
      rd(flags_low_addr, 8'(((f >> 1) & 63) << 2));
      rd(flags_mid_addr, 8'(f >> 7));
   endtask
   task automatic stk(input logic [3:0] w, input int cnt, input int dir);
      want <= w;
      @(posedge sys_clk);
      want <= 0;
      n = 0;
      repeat (12) @(posedge sys_clk) #1 n += stack_push | stack_pull;
      sp += dir * cnt;
      chk(16'(n), 16'(cnt));
      chk(stack_ptr, 16'(sp));
      chk(16'(stack_busy), 16'h0000);
   endtask
   task automatic finish_test;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      // a real edge on rst so the registers hold reset values before the first clock
      rst <= 1;
      void'($urandom(32'hf0cf));
      repeat (12) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk) #1 chk(stack_ptr, stack_reset);
      setf('0, 0);
      for (int i = 1; i < 22; i++) setf(21'(1) << (i - 1), 0);
      repeat (20) setf(21'($urandom), 0);
      setf(21'h1fffff, 1);
      // writes must not stick: status is read-only
      reg_addr <= flags_mid_addr;
      reg_wdata <= 8'hff;
      reg_wr <= 1;
      @(posedge sys_clk) reg_wr <= 0;
      setf('0, 0);
      rd(16'h1234, 8'h00);
      stk(4'h8, 5, -1);
      stk(4'h4, 2, -1);
      stk(4'h2, 5, 1);
      stk(4'h1, 2, 1);
      finish_test;
   end
   initial begin
      #100us fails++;
      finish_test;
   end
endmodule
